// File: core/asbr_regs.sv
// actuator status, limit, sensor-type and bus-fail registers with button/LED control
// Operation
// - low status byte bits 0..2 report utilisation, path and overload faults
// - bits 4..7 report fire-protection faults, only on fire variants
// - bit 8 activity, bit 9 gear disengaged, bit 10 bus monitor tripped
// - command code 4 written to the command register clears latched faults
// - fault bits 0 and 4 ignore the clear and follow their condition
// - lower limit holds 0..10000 hundredths of a percent
// - upper limit holds 2000..10000 hundredths of a percent
// - sensor type codes 0..4: none, mV, 1k, 20k, contact
// - comm-loss action 0 keeps last setpoint forever
// - with monitoring, 120 s without setpoint/override write drives to fail position
// - action 1 rapid close, 2 rapid open on timeout
// - watchdog expiry sets the bus-monitor-tripped status flag
// - yellow held over 3 s in operation toggles address mode
// - in address mode each yellow press advances pending address 1..16
// - green flashes pending address count; green press confirms it
// - yellow held over 5 s at power-up restores comm defaults, green flashes
// - green press in standard mode starts adaptation; yellow lit meanwhile
// - yellow lit steadily in address mode
// - green lit in operation, dark on malfunction
// - gear button held stops motor and sets gear flag
`include "asbr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module asbr_regs #(
  parameter int unsigned TICK_CYC   = `ASBR_TICK_CYC,
  parameter int unsigned WDOG_MS    = `ASBR_WDOG_MS,
  parameter int unsigned ADDR_HOLD  = `ASBR_ADDR_HOLD_MS,
  parameter int unsigned RESET_HOLD = `ASBR_RESET_HOLD_MS,
  parameter int unsigned BLINK_MS   = `ASBR_BLINK_MS,
  parameter bit          FIRE_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // register port from the frame decoder
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // conditions from the drive
  input  wire logic [7:0]  fault_cond_i,
  input  wire logic        activity_i,
  // push-button pins
  input  wire logic        yellow_btn_i,
  input  wire logic        green_btn_i,
  input  wire logic        gear_btn_i,
  // indications and commands
  output logic             green_led_o,
  output logic             yellow_led_o,
  output logic             motor_stop_o,
  output logic             adapt_start_o,
  output logic             factory_reset_o,
  output logic             rapid_close_o,
  output logic             rapid_open_o,
  output logic      [4:0]  bus_addr_o
);
  asbr_pkg::asbr_state_t s;
  asbr_pkg::asbr_state_t next_s;
  logic [15:0] status;
  logic [7:0]  fault_mask;
  logic        wr_setp;
  logic        yel_rise;
  logic        yel_fall;
  logic        grn_rise;

  // ==========================================================
  // status word and decode
  assign fault_mask = FIRE_VARIANT ? 8'hf7 : 8'h07;
  always_comb
  begin
    status = 16'h0000;
    status[7:0] = s.fault & fault_mask;
    status[`ASBR_BIT_ACTIVITY] = activity_i;
    status[`ASBR_BIT_GEAR]     = s.gear_sync[1];
    status[`ASBR_BIT_BUSTRIP]  = s.bus_trip;
  end
  assign wr_setp  = reg_wr_i && (reg_addr_i == `ASBR_OFS_SETPOINT ||
                                 reg_addr_i == `ASBR_OFS_OVERRIDE);
  assign yel_rise = s.yel_sync[1] && !s.yel_prev;
  assign yel_fall = !s.yel_sync[1] && s.yel_prev;
  assign grn_rise = s.grn_sync[1] && !s.grn_prev;

  // ==========================================================
  // next state
  always_comb
  begin
    next_s = s;
    next_s.yel_sync  = {s.yel_sync[0], yellow_btn_i};
    next_s.grn_sync  = {s.grn_sync[0], green_btn_i};
    next_s.gear_sync = {s.gear_sync[0], gear_btn_i};
    next_s.yel_prev  = s.yel_sync[1];
    next_s.grn_prev  = s.grn_sync[1];
    next_s.adapt_start   = 1'b0;
    next_s.factory_reset = 1'b0;
    // millisecond enable; avoids 34-bit counters for the 120 s watchdog
    next_s.tick = (s.tick_cnt == 17'(TICK_CYC - 1));
    next_s.tick_cnt = next_s.tick ? 17'h00000 : s.tick_cnt + 17'h00001;

    // latched faults: set beats clear, live bits follow condition
    if (reg_wr_i && reg_addr_i == `ASBR_OFS_COMMAND &&
        reg_wdata_i == `ASBR_CMD_CLR_FAULT)
      next_s.fault = s.fault & `ASBR_LIVE_MASK;
    next_s.fault = (next_s.fault & ~`ASBR_LIVE_MASK) | fault_cond_i |
                   (fault_cond_i & `ASBR_LIVE_MASK);
    next_s.fault = (next_s.fault & ~`ASBR_LIVE_MASK) |
                   (fault_cond_i & `ASBR_LIVE_MASK);

    // configuration writes, out-of-range values are dropped
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `ASBR_OFS_LOWER:
          if (reg_wdata_i <= `ASBR_LIMIT_FULL) next_s.lower = reg_wdata_i;
        `ASBR_OFS_UPPER:
          if (reg_wdata_i >= `ASBR_UPPER_MIN && reg_wdata_i <= `ASBR_LIMIT_FULL)
            next_s.upper = reg_wdata_i;
        `ASBR_OFS_SENSOR:
          if (reg_wdata_i <= `ASBR_SENSOR_MAX) next_s.sensor = reg_wdata_i;
        `ASBR_OFS_COMMLOSS:
          if (reg_wdata_i <= `ASBR_ACTION_MAX) next_s.action = reg_wdata_i;
        default: ;
      endcase
    end

    // communication watchdog
    // new action takes effect at once, so a trip never outlives monitoring
    if (wr_setp || next_s.action == 16'h0000)
    begin
      next_s.wdog_ms  = 17'h00000;
      next_s.bus_trip = 1'b0;
    end
    else if (s.tick && !s.bus_trip)
    begin
      if (s.wdog_ms == 17'(WDOG_MS - 1))
        next_s.bus_trip = 1'b1;
      else
        next_s.wdog_ms = s.wdog_ms + 17'h00001;
    end
    next_s.rapid_close = next_s.bus_trip && next_s.action == 16'h0001;
    next_s.rapid_open  = next_s.bus_trip && next_s.action == 16'h0002;

    // yellow hold timer, one shot per press
    next_s.hold_done = s.hold_done;
    if (!s.yel_sync[1])
    begin
      next_s.hold_ms   = 13'h0000;
      next_s.hold_done = 1'b0;
    end
    else if (s.tick && s.hold_ms != 13'h1fff)
      next_s.hold_ms = s.hold_ms + 13'h0001;

    // blink pacing for the green address pulses
    if (s.tick)
    begin
      if (s.blink_ms == 8'(BLINK_MS - 1))
      begin
        next_s.blink_ms = 8'h00;
        next_s.blink_ph = !s.blink_ph;
        if (s.blink_ph)
          next_s.pulse_idx = (s.pulse_idx == s.pend_addr + 5'h03) ? 5'h00 :
                             s.pulse_idx + 5'h01;
      end
      else
        next_s.blink_ms = s.blink_ms + 8'h01;
    end

    case (s.mode)
      asbr_pkg::ASBR_POWERUP:
      begin
        // only a yellow held from power-up may restore defaults
        // decide only at the first tick, once the pin synchroniser has filled;
        // limitation: TICK_CYC must be 2 or more
        if (s.tick && !s.yel_sync[1] && s.hold_ms == 13'h0000 && !s.factory_blink)
          next_s.mode = asbr_pkg::ASBR_NORMAL;
        else if (yel_fall)
          next_s.mode = asbr_pkg::ASBR_NORMAL;
        else if (!s.hold_done && s.hold_ms > 13'(RESET_HOLD))
        begin
          next_s.hold_done     = 1'b1;
          next_s.factory_reset = 1'b1;
          next_s.factory_blink = 1'b1;
          next_s.bus_addr      = `ASBR_ADDR_MIN;
          next_s.pend_addr     = `ASBR_ADDR_MIN;
        end
      end
      asbr_pkg::ASBR_NORMAL:
      begin
        next_s.factory_blink = 1'b0;
        if (!s.hold_done && s.hold_ms > 13'(ADDR_HOLD))
        begin
          next_s.hold_done = 1'b1;
          next_s.mode      = asbr_pkg::ASBR_ADDRESS;
          next_s.pend_addr = s.bus_addr;
          next_s.pulse_idx = 5'h00;
        end
        else if (grn_rise)
          next_s.adapt_start = 1'b1;
      end
      asbr_pkg::ASBR_ADDRESS:
      begin
        if (!s.hold_done && s.hold_ms > 13'(ADDR_HOLD))
        begin
          next_s.hold_done = 1'b1;
          next_s.mode      = asbr_pkg::ASBR_NORMAL;
        end
        else if (yel_fall && !s.hold_done)
          next_s.pend_addr = (s.pend_addr == `ASBR_ADDR_MAX) ? `ASBR_ADDR_MIN :
                             s.pend_addr + 5'h01;
        else if (grn_rise)
        begin
          next_s.bus_addr = s.pend_addr;
          next_s.mode     = asbr_pkg::ASBR_NORMAL;
        end
      end
      default: next_s.mode = asbr_pkg::ASBR_NORMAL;
    endcase

    // indications
    if (next_s.mode == asbr_pkg::ASBR_ADDRESS)
      next_s.green_led = s.blink_ph && (s.pulse_idx < s.pend_addr);
    else if (s.factory_blink)
      next_s.green_led = s.blink_ph;
    else
      next_s.green_led = (status[7:0] == 8'h00);
    next_s.yellow_led = activity_i ||
                        next_s.mode == asbr_pkg::ASBR_ADDRESS;

    case (reg_addr_i)
      `ASBR_OFS_STATUS:   next_s.rdata = status;
      `ASBR_OFS_LOWER:    next_s.rdata = s.lower;
      `ASBR_OFS_UPPER:    next_s.rdata = s.upper;
      `ASBR_OFS_SENSOR:   next_s.rdata = s.sensor;
      `ASBR_OFS_COMMLOSS: next_s.rdata = s.action;
      default:            next_s.rdata = 16'h0000;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.mode      <= asbr_pkg::ASBR_POWERUP;
      s.lower     <= `ASBR_RST_LOWER;
      s.upper     <= `ASBR_RST_UPPER;
      s.sensor    <= `ASBR_RST_SENSOR;
      s.action    <= `ASBR_RST_ACTION;
      s.pend_addr <= `ASBR_ADDR_MIN;
      s.bus_addr  <= `ASBR_ADDR_MIN;
    end
    else
      s <= next_s;
  end

  assign reg_rdata_o     = s.rdata;
  assign green_led_o     = s.green_led;
  assign yellow_led_o    = s.yellow_led;
  assign motor_stop_o    = s.gear_sync[1];
  assign adapt_start_o   = s.adapt_start;
  assign factory_reset_o = s.factory_reset;
  assign rapid_close_o   = s.rapid_close;
  assign rapid_open_o    = s.rapid_open;
  assign bus_addr_o      = s.bus_addr;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_status_zero_bits: assert property (
    reg_addr_i == `ASBR_OFS_STATUS |=> (reg_rdata_o[15:11] == 5'h00 && !reg_rdata_o[3]))
    else $error("unassigned status bits not zero");
  a_clear_faults: assert property (
    reg_wr_i && reg_addr_i == `ASBR_OFS_COMMAND && reg_wdata_i == `ASBR_CMD_CLR_FAULT
    && fault_cond_i == 8'h00 |=> s.fault == 8'h00)
    else $error("fault clear command ignored");
  a_live_fault: assert property (
    fault_cond_i[0] |=> s.fault[0])
    else $error("live fault bit lost");
  a_lower_range: assert property (s.lower <= `ASBR_LIMIT_FULL)
    else $error("lower limit out of range");
  a_upper_range: assert property (
    s.upper >= `ASBR_UPPER_MIN && s.upper <= `ASBR_LIMIT_FULL)
    else $error("upper limit out of range");
  a_sensor_range: assert property (s.sensor <= `ASBR_SENSOR_MAX)
    else $error("sensor type out of range");
  a_no_monitor: assert property (s.action == 16'h0000 |-> !s.bus_trip)
    else $error("trip without monitoring");
  a_wdog_restart: assert property (wr_setp |=> s.wdog_ms == 17'h00000)
    else $error("watchdog not restarted");
  a_trip_drive: assert property (
    s.bus_trip && s.action == 16'h0001 && !wr_setp && !reg_wr_i |=> rapid_close_o)
    else $error("rapid close missing");
  a_gear_stop: assert property (
    gear_btn_i [*3] |-> motor_stop_o)
    else $error("gear held but motor runs");

  c_bus_trip: cover property (!s.bus_trip ##1 s.bus_trip);
  c_addr_mode: cover property (s.mode == asbr_pkg::ASBR_ADDRESS);
  c_factory: cover property (factory_reset_o);
  c_adapt: cover property (adapt_start_o);
endmodule : asbr_regs
`default_nettype wire

// File: core/asbr_params.svh
// offsets, field positions, reset values and timing figures of the status bank
`ifndef ASBR_PARAMS_SVH
`define ASBR_PARAMS_SVH
// ==========================================================
// register offsets
`define ASBR_OFS_SETPOINT   16'h0001
`define ASBR_OFS_OVERRIDE   16'h0002
`define ASBR_OFS_COMMAND    16'h0003
`define ASBR_OFS_STATUS     16'h0069
`define ASBR_OFS_LOWER      16'h006a
`define ASBR_OFS_UPPER      16'h006b
`define ASBR_OFS_SENSOR     16'h006c
`define ASBR_OFS_COMMLOSS   16'h006d
// ==========================================================
// fields and codes
`define ASBR_CMD_CLR_FAULT  16'h0004
`define ASBR_BIT_ACTIVITY   8
`define ASBR_BIT_GEAR       9
`define ASBR_BIT_BUSTRIP    10
`define ASBR_LIVE_MASK      8'h11
`define ASBR_FIRE_MASK      8'hf0
`define ASBR_LIMIT_FULL     16'h2710
`define ASBR_UPPER_MIN      16'h07d0
`define ASBR_SENSOR_MAX     16'h0004
`define ASBR_ACTION_MAX     16'h0002
`define ASBR_ADDR_MIN       5'h01
`define ASBR_ADDR_MAX       5'h10
// ==========================================================
// reset values
`define ASBR_RST_LOWER      16'h0000
`define ASBR_RST_UPPER      16'h2710
`define ASBR_RST_SENSOR     16'h0000
`define ASBR_RST_ACTION     16'h0000
// ==========================================================
// timing: clock in MHz, times in ms, ASBR_WDOG_S in s
`define ASBR_CLK_MHZ        100
`define ASBR_TICK_MS        1
`define ASBR_TICK_CYC       (`ASBR_TICK_MS * 1000 * `ASBR_CLK_MHZ)
`define ASBR_WDOG_S         120
`define ASBR_WDOG_MS        (`ASBR_WDOG_S * 1000)
`define ASBR_ADDR_HOLD_MS   3000
`define ASBR_RESET_HOLD_MS  5000
`define ASBR_BLINK_MS       250
`endif

// File: core/asbr_pkg.sv
// types of the actuator status and bus-fail register bank
package asbr_pkg;
  typedef enum logic [2:0] {
    ASBR_POWERUP = 3'b001,
    ASBR_NORMAL  = 3'b010,
    ASBR_ADDRESS = 3'b100
  } asbr_mode_t;

  typedef struct packed {
    logic [1:0]  yel_sync;
    logic [1:0]  grn_sync;
    logic [1:0]  gear_sync;
    logic        yel_prev;
    logic        grn_prev;
    asbr_mode_t  mode;
    logic [16:0] tick_cnt;
    logic        tick;
    logic [16:0] wdog_ms;
    logic        bus_trip;
    logic [12:0] hold_ms;
    logic        hold_done;
    logic [7:0]  fault;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] sensor;
    logic [15:0] action;
    logic [4:0]  pend_addr;
    logic [4:0]  bus_addr;
    logic [7:0]  blink_ms;
    logic        blink_ph;
    logic [4:0]  pulse_idx;
    logic        factory_blink;
    logic [15:0] rdata;
    logic        green_led;
    logic        yellow_led;
    logic        adapt_start;
    logic        factory_reset;
    logic        rapid_close;
    logic        rapid_open;
  } asbr_state_t;
endpackage : asbr_pkg

// File: verification/asbr_master.sv
// register-port master standing in for the bus frame decoder
`timescale 1ns/1ps
`default_nettype none
module asbr_master (
  // clock
  input  wire logic        core_clk_i,
  // register port
  input  wire logic [15:0] reg_rdata_i,
  output var  logic        reg_wr_o,
  output var  logic [15:0] reg_addr_o,
  output var  logic [15:0] reg_wdata_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_addr_o  = 16'h0000;
    reg_wdata_o = 16'h0000;
  end
  // data inverted after the strobe so a stale word is never taken for a new one
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr
  // answer is registered: sample on the second edge after the address
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    repeat (2) @(posedge core_clk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : asbr_master
`default_nettype wire

// File: verification/actuator_status_busfail_regs_test.sv
// self-checking bench of the status, limit and bus-fail register bank
`timescale 1ns/1ps
`default_nettype none
module actuator_status_busfail_regs_test;
  logic        core_clk, rst_n, reg_wr, yel, grn, gear, activity, g_prev;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [7:0]  fault_cond;
  logic        green_led, yellow_led, motor_stop, adapt_start;
  logic        factory_reset, rapid_close, rapid_open;
  logic [4:0]  bus_addr;
  int          fail_count, n_checks, n_adapt, n_fact, n_blink;

  asbr_regs #(.TICK_CYC(10), .WDOG_MS(20), .ADDR_HOLD(5), .RESET_HOLD(8), .BLINK_MS(2))
    i_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .fault_cond_i(fault_cond),
    .activity_i(activity), .yellow_btn_i(yel), .green_btn_i(grn), .gear_btn_i(gear),
    .green_led_o(green_led), .yellow_led_o(yellow_led), .motor_stop_o(motor_stop),
    .adapt_start_o(adapt_start), .factory_reset_o(factory_reset),
    .rapid_close_o(rapid_close), .rapid_open_o(rapid_open), .bus_addr_o(bus_addr));

  asbr_master i_master (.core_clk_i(core_clk), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // event counters for pulses and green flashes
  always @(posedge core_clk)
  begin
    g_prev <= green_led;
    if (adapt_start === 1'b1)
      n_adapt++;
    if (factory_reset === 1'b1)
      n_fact++;
    if (green_led === 1'b1 && g_prev === 1'b0)
      n_blink++;
  end

  // ==========================================================
  // checking tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    i_master.rd(a, rv);
    chk(rv, exp, "register read");
  endtask : rchk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_master.wr(a, d);
  endtask : wr
  task automatic press(input bit green, input int hold);
    @(posedge core_clk);
    if (green)
      grn <= 1'b1;
    else
      yel <= 1'b1;
    repeat (hold) @(posedge core_clk);
    grn <= 1'b0;
    yel <= 1'b0;
    repeat (30) @(posedge core_clk);
  endtask : press
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // a hang is cut short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("[FAIL] %0t run did not finish in time", $time);
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    yel = 1'b0;
    grn = 1'b0;
    gear = 1'b0;
    activity = 1'b0;
    fault_cond = 8'h00;
    g_prev = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    chk({11'h000, bus_addr}, 16'h0001, "bus address after reset");
    rchk(16'h006a, 16'h0000);
    rchk(16'h006b, 16'h2710);
    rchk(16'h006c, 16'h0000);
    rchk(16'h006d, 16'h0000);
    rchk(16'h00ff, 16'h0000);
    // range edges: in-range kept, out-of-range dropped
    wr(16'h006a, 16'h2710);
    wr(16'h006a, 16'h2711);
    rchk(16'h006a, 16'h2710);
    wr(16'h006b, 16'h07cf);
    rchk(16'h006b, 16'h2710);
    wr(16'h006b, 16'h07d0);
    wr(16'h006b, 16'h2711);
    rchk(16'h006b, 16'h07d0);
    for (int k = 0; k <= 5; k++)
    begin
      wr(16'h006c, 16'(k));
      rchk(16'h006c, (k > 4) ? 16'h0004 : 16'(k));
    end
    wr(16'h006d, 16'h0003);
    rchk(16'h006d, 16'h0000);
    // status word: latch, clear, live bits
    fault_cond <= 8'hff;
    repeat (3) @(posedge core_clk);
    rchk(16'h0069, 16'h0007);
    chk({15'h0000, green_led}, 16'h0000, "green lit with fault");
    wr(16'h0069, 16'h0000);
    fault_cond <= 8'h00;
    rchk(16'h0069, 16'h0006);
    wr(16'h0003, 16'h0004);
    rchk(16'h0069, 16'h0000);
    chk({15'h0000, green_led}, 16'h0001, "green dark in operation");
    fault_cond <= 8'h11;
    wr(16'h0003, 16'h0004);
    rchk(16'h0069, 16'h0001);
    fault_cond <= 8'h00;
    activity <= 1'b1;
    gear <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk(16'h0069, 16'h0300);
    chk({15'h0000, motor_stop}, 16'h0001, "motor not stopped");
    chk({15'h0000, yellow_led}, 16'h0001, "yellow dark in activity");
    activity <= 1'b0;
    gear <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({15'h0000, motor_stop}, 16'h0000, "motor still stopped");
    // bus watchdog: 20 ticks of 10 cycles
    wr(16'h006d, 16'h0001);
    wr(16'h0001, 16'h0000);
    repeat (160) @(posedge core_clk);
    rchk(16'h0069, 16'h0000);
    repeat (80) @(posedge core_clk);
    rchk(16'h0069, 16'h0400);
    chk({14'h0000, rapid_close, rapid_open}, 16'h0002, "rapid close");
    wr(16'h006d, 16'h0002);
    wr(16'h0002, 16'h0000);
    @(posedge core_clk);
    chk({14'h0000, rapid_close, rapid_open}, 16'h0000, "trip not cleared");
    repeat (160) @(posedge core_clk);
    rchk(16'h0069, 16'h0000);
    repeat (80) @(posedge core_clk);
    rchk(16'h0069, 16'h0400);
    chk({14'h0000, rapid_close, rapid_open}, 16'h0001, "rapid open");
    wr(16'h006d, 16'h0000);
    repeat (300) @(posedge core_clk);
    rchk(16'h0069, 16'h0000);
    chk({14'h0000, rapid_close, rapid_open}, 16'h0000, "monitor off acted");
    // buttons and indications
    n_adapt = 0;
    press(1'b1, 30);
    chk(16'(n_adapt), 16'h0001, "adaptation pulses");
    press(1'b0, 80);
    chk({15'h0000, yellow_led}, 16'h0001, "address mode yellow");
    repeat (3) press(1'b0, 30);
    n_blink = 0;
    repeat (600) @(posedge core_clk);
    // address 4 gives 4 flashes per 8-slot period of 320 cycles: 7 or 8 in 600
    chk(16'(n_blink >= 6 && n_blink <= 9), 16'h0001, "green flash count");
    chk({15'h0000, yellow_led}, 16'h0001, "yellow not steady");
    press(1'b1, 30);
    chk({11'h000, bus_addr}, 16'h0004, "confirmed address");
    chk({15'h0000, yellow_led}, 16'h0000, "still in address mode");
    press(1'b0, 80);
    press(1'b0, 80);
    chk({15'h0000, yellow_led}, 16'h0000, "address mode not left");
    chk({11'h000, bus_addr}, 16'h0004, "address taken without confirm");
    chk(16'(n_fact), 16'h0000, "spurious factory reset");
    // power-up with yellow held: factory defaults
    rst_n <= 1'b0;
    yel <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // count only after the factory pulse; the lamp lighting after reset is no flash
    repeat (120) @(posedge core_clk);
    n_blink = 0;
    repeat (80) @(posedge core_clk);
    yel <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(16'(n_fact), 16'h0001, "factory reset pulses");
    chk(16'(n_blink >= 1), 16'h0001, "green not flashing");
    chk({11'h000, bus_addr}, 16'h0001, "factory address");
    print_verdict();
  end
endmodule : actuator_status_busfail_regs_test
`default_nettype wire
